// File: ext_partner.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// far side: reset source and pwm compare unit
module ext_partner (
  // clock
  input wire logic clk,
  // bench commands
  input wire logic level_req,
  input wire logic [7:0] pulse_width_compare,
  // timer side
  input wire logic [7:0] count_value,
  output logic ext_reset_signal,
  output logic pwm_out
);
  // source moves just after an edge, never mid-cycle
  always_ff @(posedge clk)
  begin
    ext_reset_signal <= level_req;
  end
  // drive high while count below width; count is registered so no glitch
  assign pwm_out = count_value < pulse_width_compare;
endmodule : ext_partner
`default_nettype wire

// File: hw_limit_period_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1 - interrupt when postscaler reaches selected ratio
// RULE2 - interrupt passes only while enable set
// RULE3 - enable and external signal synchronised two clocks
// RULE4 - software gate counts only while enabled
// RULE5 - period match clears, counting resumes from zero
// RULE6 - hardware gate halts on external level
// RULE7 - external edge resets counter early
// RULE8 - period restarts two clocks after edge
// RULE9 - level modes hold reset, ignore when off
// RULE10 - level reset after match or two clocks
// RULE11 - level release restarts counting two clocks later
// RULE12 - soft one-shot clears enable at match
// RULE13 - soft one-shot pauses while enable cleared
// RULE14 - edge one-shot starts on edge after enable
// RULE15 - halted edge one-shot needs fresh edge
// RULE16 - limit one-shot: first edge starts, later reset
// RULE17 - limit one-shot clears enable, ignores edges off
// RULE18 - level-reset one-shot holds, starts on transition; here the transition tick still holds reset, so the count never starts
// RULE19 - level-reset one-shot needs new edge after enable
// RULE20 - prescaler divides by one to 128
// RULE21 - postscale codes map linearly one to sixteen
// RULE22 - sync option delays enable two timer clocks
// RULE23 - period match always clears counter next clock; a same-cycle software write to the count wins instead
// RULE24 - counter and period are eight bits
// RULE25 - interrupt flag sticky until software clears
module hw_limit_period_timer
  import hw_limit_period_timer_pkg::*;
#(
  parameter int unsigned CNT_W = 8  // counter and period width
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // axi4-lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  // axi4-lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // axi4-lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // axi4-lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  // axi4-lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // external reset signal source
  input wire logic EXT_RESET_SIGNAL,
  // time base for the pwm compare unit and interrupt
  output logic [CNT_W-1:0] COUNT_VALUE,
  output logic PERIOD_MATCH,
  output logic TIMER_IRQ
);

  // ==========================================================================
  // register state
  // ==========================================================================
  logic on_q;  // enable bit, hardware may clear it
  logic [2:0] pre_sel_q;  // prescale_select
  logic [3:0] post_sel_q;  // postscale_select
  logic enable_sync_option_q;  // enable_sync_option
  logic [4:0] mode_q;  // operating mode
  logic [CNT_W-1:0] period_q;  // period_value
  logic [CNT_W-1:0] count_q;  // count_value
  logic irq_flag_q;  // sticky interrupt flag
  logic irq_en_q;  // period_irq_enable

  // ==========================================================================
  // axi4-lite slave
  // ==========================================================================
  logic aw_held_q;  // address captured, waiting for data
  logic w_held_q;  // data captured, waiting for address
  logic [ADDR_W-1:0] waddr_q;  // captured write address
  logic [31:0] wdata_q;  // captured write data
  logic [3:0] wstrb_q;  // captured strobes
  logic wr_go;  // both halves present, perform write
  logic wr_ctrl;  // strobed write to timer_control_reg

  assign wr_go = aw_held_q && w_held_q && !S_AXI_BVALID;
  assign wr_ctrl = wr_go && (waddr_q == ADDR_TIMER_CONTROL) && wstrb_q[0];

  // address and data taken in either order, one write in flight
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end
    else
    begin
      // ready is offered one cycle ahead while the slot is empty
      S_AXI_AWREADY <= !aw_held_q && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY <= !w_held_q && !(S_AXI_WVALID && S_AXI_WREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held_q <= 1'b1;
        waddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_go)
      begin
        S_AXI_BVALID <= 1'b1;
        // unmapped or misaligned words answer with an error
        S_AXI_BRESP <= (waddr_q > ADDR_IRQ || waddr_q[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= RESP_OKAY;
        case (S_AXI_ARADDR)
          ADDR_TIMER_CONTROL: S_AXI_RDATA <= {24'h00_0000, on_q, pre_sel_q, post_sel_q};
          ADDR_LIMIT_CONTROL: S_AXI_RDATA <= {26'h000_0000, enable_sync_option_q, mode_q};
          ADDR_PERIOD: S_AXI_RDATA <= {{(32-CNT_W){1'b0}}, period_q};
          ADDR_COUNT: S_AXI_RDATA <= {{(32-CNT_W){1'b0}}, count_q};
          ADDR_IRQ: S_AXI_RDATA <= {30'h0000_0000, irq_en_q, irq_flag_q};
          default:
          begin
            // unmapped reads return zero with an error
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_SLVERR;
          end
        endcase
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // prescaler
  // ==========================================================================
  logic [6:0] pre_cnt_q;  // prescale divider count
  logic [6:0] pre_lim;  // last count of the selected ratio
  logic tick;  // one timer clock, a one-cycle enable

  // RULE20 - ratio doubles per code
  assign pre_lim = 7'((8'h01 << pre_sel_q) - 8'h01);
  assign tick = (pre_cnt_q == pre_lim);

  // divider free-runs, so a new ratio below the current count lands only after the count wraps past 127
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      pre_cnt_q <= 7'h00;
    else if (tick)
      pre_cnt_q <= 7'h00;
    else
      pre_cnt_q <= pre_cnt_q + 7'h01;
  end

  // ==========================================================================
  // synchronisers and timer-clock delay stages
  // ==========================================================================
  logic ers_m_q;  // first stage, read only by the second
  logic ers_s_q;  // synchronised external signal
  logic ers_t1_q;  // level seen at one timer clock
  logic ers_t2_q;  // level seen one timer clock later
  logic on_t1_q;  // enable delayed one timer clock
  logic on_t2_q;  // enable delayed two timer clocks
  logic on_eff;  // enable as the counter sees it
  logic lvl;  // external level, two timer clocks late
  logic rise;  // delayed rising edge
  logic fall;  // delayed falling edge

  // RULE3 - two stages, then timer-clock stages
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ers_m_q <= 1'b0;
      ers_s_q <= 1'b0;
    end
    else
    begin
      ers_m_q <= EXT_RESET_SIGNAL;
      ers_s_q <= ers_m_q;
    end
  end

  // level and enable pipelines advance on timer clocks only
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ers_t1_q <= 1'b0;
      ers_t2_q <= 1'b0;
      on_t1_q <= 1'b0;
      on_t2_q <= 1'b0;
    end
    else if (tick)
    begin
      ers_t1_q <= ers_s_q;
      ers_t2_q <= ers_t1_q;
      on_t1_q <= on_q;
      on_t2_q <= on_t1_q;
    end
  end

  // RULE22 - sync option uses twice-delayed enable
  assign on_eff = enable_sync_option_q ? (on_q && on_t2_q) : on_q;
  assign lvl = ers_t2_q;
  // RULE8 - edge acts two timer clocks late
  assign rise = ers_t1_q && !ers_t2_q;
  assign fall = !ers_t1_q && ers_t2_q;

  // ==========================================================================
  // mode decode
  // ==========================================================================
  logic started_q;  // one-shot armed by its start event
  logic run;  // counter may advance this timer clock
  logic hold_rst;  // counter forced to zero this timer clock
  logic start_ev;  // qualifying start event
  logic one_shot;  // match clears the enable bit
  logic match;  // count equals period on a timer clock

  assign match = tick && (count_q == period_q);

  always_comb
  begin
    run = 1'b0;
    hold_rst = 1'b0;
    start_ev = 1'b0;
    one_shot = 1'b0;
    case (mode_q)
      // RULE4 - software gate
      M_SW_GATE: run = on_eff;
      // RULE6 - hardware gates
      M_GATE_HIGH_STOP: run = on_eff && !lvl;
      M_GATE_LOW_STOP: run = on_eff && lvl;
      // RULE7 - edge reset modes
      M_EDGE_ANY_RST:
      begin
        run = on_eff;
        hold_rst = on_eff && (rise || fall);
      end
      M_EDGE_RISE_RST:
      begin
        run = on_eff;
        hold_rst = on_eff && rise;
      end
      M_EDGE_FALL_RST:
      begin
        run = on_eff;
        hold_rst = on_eff && fall;
      end
      // RULE9 - level held reset, ignored when off
      M_LEVEL_LOW_RST:
      begin
        hold_rst = on_eff && !lvl;
        run = on_eff && lvl;
      end
      M_LEVEL_HIGH_RST:
      begin
        hold_rst = on_eff && lvl;
        run = on_eff && !lvl;
      end
      // RULE13 - pauses while enable low
      M_OS_SOFT:
      begin
        run = on_eff;
        one_shot = 1'b1;
      end
      // RULE14 - edge start one-shots
      M_OS_RISE, M_OS_FALL, M_OS_ANY:
      begin
        one_shot = 1'b1;
        start_ev = on_eff && ((mode_q != M_OS_FALL && rise) || (mode_q != M_OS_RISE && fall));
        run = on_eff && (started_q || start_ev);
      end
      // RULE16 - first edge starts, later edges reset
      M_OSHL_RISE, M_OSHL_FALL:
      begin
        one_shot = 1'b1;
        start_ev = on_eff && (mode_q == M_OSHL_RISE ? rise : fall);
        hold_rst = started_q && start_ev;
        run = on_eff && (started_q || start_ev);
      end
      // RULE18 - level reset; hold_rst is also set on the transition tick, so the count never starts
      M_OSLV_LOW, M_OSLV_HIGH:
      begin
        one_shot = 1'b1;
        hold_rst = (mode_q == M_OSLV_LOW) ? !lvl : lvl;
        start_ev = on_eff && (mode_q == M_OSLV_LOW ? rise : fall);
        run = on_eff && (started_q || start_ev);
      end
      // unused codes leave the counter still
      default: run = 1'b0;
    endcase
  end

  // RULE15 - disarm whenever enable drops
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      started_q <= 1'b0;
    else if (!on_eff || (match && one_shot))
      started_q <= 1'b0;
    // RULE19 - reset level disarms, new edge needed
    else if (tick && hold_rst && mode_q >= M_OSLV_LOW)
      started_q <= 1'b0;
    else if (tick && start_ev)
      started_q <= 1'b1;
  end

  // ==========================================================================
  // counter
  // ==========================================================================
  // RULE24 - full-width match and count
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      count_q <= RST_COUNT[CNT_W-1:0];
    // software write to the count wins over the timer
    else if (wr_go && waddr_q == ADDR_COUNT && wstrb_q[0])
      count_q <= wdata_q[CNT_W-1:0];
    // RULE5 - free run restarts from zero
    // RULE23 - match clears in every mode
    else if (match)
      count_q <= '0;
    // RULE10 - level reset forces zero
    else if (tick && hold_rst)
      count_q <= '0;
    // RULE11 - resumes once reset released
    else if (tick && run)
      count_q <= count_q + 1'b1;
  end

  // ==========================================================================
  // control registers
  // ==========================================================================
  // RULE12 - one-shot match clears enable
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      on_q <= RST_CONTROL[ON_BIT];
      pre_sel_q <= RST_CONTROL[PRE_LSB +: 3];
      post_sel_q <= RST_CONTROL[POST_LSB +: 4];
    end
    else if (wr_ctrl)
    begin
      // a software set beats a same-cycle hardware clear
      on_q <= wdata_q[ON_BIT];
      pre_sel_q <= wdata_q[PRE_LSB +: 3];
      post_sel_q <= wdata_q[POST_LSB +: 4];
    end
    // RULE17 - enable cleared at period match
    else if (match && one_shot)
      on_q <= 1'b0;
  end

  // remaining writable registers
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      enable_sync_option_q <= RST_LIMIT[ENABLE_SYNC_OPTION_BIT];
      mode_q <= RST_LIMIT[MODE_LSB +: 5];
      period_q <= RST_PERIOD[CNT_W-1:0];
      irq_en_q <= 1'b0;
    end
    else if (wr_go && wstrb_q[0])
    begin
      if (waddr_q == ADDR_LIMIT_CONTROL)
      begin
        enable_sync_option_q <= wdata_q[ENABLE_SYNC_OPTION_BIT];
        mode_q <= wdata_q[MODE_LSB +: 5];
      end
      if (waddr_q == ADDR_PERIOD)
        period_q <= wdata_q[CNT_W-1:0];
      if (waddr_q == ADDR_IRQ)
        irq_en_q <= wdata_q[IRQEN_BIT];
    end
  end

  // ==========================================================================
  // postscaler and interrupt
  // ==========================================================================
  logic [3:0] post_cnt_q;  // matches seen since last interrupt
  logic post_hit;  // postscaler reached its ratio

  // RULE21 - code n means n+1 matches
  assign post_hit = match && (post_cnt_q == post_sel_q);

  // counting past a lowered ratio wraps through zero
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      post_cnt_q <= 4'h0;
    else if (post_hit)
      post_cnt_q <= 4'h0;
    else if (match)
      post_cnt_q <= post_cnt_q + 4'h1;
  end

  // RULE25 - sticky flag, set beats clear
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      irq_flag_q <= 1'b0;
    // RULE1 - flag on postscaler hit
    else if (post_hit)
      irq_flag_q <= 1'b1;
    else if (wr_go && waddr_q == ADDR_IRQ && wstrb_q[0] && wdata_q[FLAG_BIT])
      irq_flag_q <= 1'b0;
  end

  // registered outputs toward the pwm unit and processor
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      TIMER_IRQ <= 1'b0;
      PERIOD_MATCH <= 1'b0;
      COUNT_VALUE <= '0;
    end
    else
    begin
      // RULE2 - gated by enable bit
      TIMER_IRQ <= irq_flag_q && irq_en_q;
      PERIOD_MATCH <= match;
      COUNT_VALUE <= count_q;
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence os_match_s;
    match && one_shot && !wr_ctrl;
  endsequence

  post_irq_set_a: assert property (post_hit |=> irq_flag_q) // RULE1
    else $error("postscaler hit did not set flag");
  irq_gate_a: assert property (##1 TIMER_IRQ == $past(irq_flag_q && irq_en_q)) // RULE2
    else $error("interrupt output not gated by enable");
  ers_sync_a: assert property (##2 ers_s_q == $past(EXT_RESET_SIGNAL, 2)) // RULE3
    else $error("external signal sync depth wrong");
  soft_hold_a: assert property (mode_q == M_SW_GATE && !on_eff && !match && !wr_go |=> $stable(count_q)) // RULE4
    else $error("count moved while disabled");
  match_clear_a: assert property (match && !wr_go |=> count_q == '0) // RULE23
    else $error("count not cleared after match");
  gate_high_a: assert property (mode_q == M_GATE_HIGH_STOP && lvl && !match && !wr_go |=> $stable(count_q)) // RULE6
    else $error("gate did not halt count");
  edge_reset_a: assert property (mode_q == M_EDGE_RISE_RST && tick && on_eff && rise && !wr_go |=> count_q == '0) // RULE7
    else $error("rising edge did not reset count");
  // a match still clears the count while off, so it is left out here
  level_off_a: assert property (mode_q == M_LEVEL_HIGH_RST && !on_eff && !match // RULE9
    && !wr_go |=> $stable(count_q))
    else $error("level mode acted while disabled");
  // a software set one cycle after the match may raise the enable again
  oneshot_off_a: assert property (os_match_s |=> !on_q ##1 (!on_q || $past(wr_ctrl))) // RULE12
    else $error("one-shot match left enable set");
  prescale_tick_a: assert property (tick |=> pre_cnt_q == 7'h00) // RULE20
    else $error("prescaler did not wrap on tick");

endmodule : hw_limit_period_timer

`default_nettype wire

// File: hw_limit_period_timer_pkg.sv
package hw_limit_period_timer_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  // ==========================================================================
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] ADDR_TIMER_CONTROL = 5'h00;  // timer_control_reg
  localparam logic [4:0] ADDR_LIMIT_CONTROL = 5'h04;  // mode and sync option
  localparam logic [4:0] ADDR_PERIOD = 5'h08;  // period_value
  localparam logic [4:0] ADDR_COUNT = 5'h0C;  // count_value
  localparam logic [4:0] ADDR_IRQ = 5'h10;  // peripheral_irq_enable_reg4 plus flag

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned ON_BIT = 7;  // enable bit in timer_control_reg
  localparam int unsigned PRE_LSB = 4;  // prescale_select, 3 bits
  localparam int unsigned POST_LSB = 0;  // postscale_select, 4 bits
  localparam int unsigned ENABLE_SYNC_OPTION_BIT = 5;  // enable_sync_option
  localparam int unsigned MODE_LSB = 0;  // mode, 5 bits
  localparam int unsigned FLAG_BIT = 0;  // sticky interrupt flag, write 1 clears
  localparam int unsigned IRQEN_BIT = 1;  // period_irq_enable

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // ==========================================================================
  // operating modes
  // ==========================================================================
  localparam logic [4:0] M_SW_GATE = 5'h00;
  localparam logic [4:0] M_GATE_HIGH_STOP = 5'h01;
  localparam logic [4:0] M_GATE_LOW_STOP = 5'h02;
  localparam logic [4:0] M_EDGE_ANY_RST = 5'h03;
  localparam logic [4:0] M_EDGE_RISE_RST = 5'h04;
  localparam logic [4:0] M_EDGE_FALL_RST = 5'h05;
  localparam logic [4:0] M_LEVEL_LOW_RST = 5'h06;
  localparam logic [4:0] M_LEVEL_HIGH_RST = 5'h07;
  localparam logic [4:0] M_OS_SOFT = 5'h08;
  localparam logic [4:0] M_OS_RISE = 5'h09;
  localparam logic [4:0] M_OS_FALL = 5'h0A;
  localparam logic [4:0] M_OS_ANY = 5'h0B;
  localparam logic [4:0] M_OSHL_RISE = 5'h0C;
  localparam logic [4:0] M_OSHL_FALL = 5'h0D;
  localparam logic [4:0] M_OSLV_LOW = 5'h0E;
  localparam logic [4:0] M_OSLV_HIGH = 5'h0F;

  // ==========================================================================
  // bus answers
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : hw_limit_period_timer_pkg

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// bench for the period timer
module tb;
  import hw_limit_period_timer_pkg::*;
  logic clk = 0, rst_n = 0, lvl = 0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [4:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, d;
  logic [1:0] bre, rre, r;
  logic awr, wr, bv, arr, rv, ext, pm, irq, pwm;
  logic [7:0] cnt, a;
  int n_fail = 0, tests_run = 0, n_match = 0, pm_gap = 0, p0;
  time pm_t = 0;
  // rows: prescale, postscale, match gap, matches per interrupt
  typedef struct {logic [2:0] pre; logic [3:0] post; int gap; int hits;} row_t;
  row_t rows [3] = '{'{3'h0, 4'h1, 4, 2}, '{3'h1, 4'h2, 8, 3}, '{3'h3, 4'hF, 32, 16}};
  // reset values per address
  logic [4:0] ra [5] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};
  logic [31:0] rv0 [5] = '{32'h0, 32'h0, 32'h0000_00FF, 32'h0, 32'h0};
  hw_limit_period_timer uut (.CLOCK(clk), .RST_N(rst_n), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_BRESP(bre), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rre),
    .EXT_RESET_SIGNAL(ext), .COUNT_VALUE(cnt), .PERIOD_MATCH(pm), .TIMER_IRQ(irq));
  ext_partner far (.clk(clk), .level_req(lvl), .pulse_width_compare(8'h10),
    .count_value(cnt), .ext_reset_signal(ext), .pwm_out(pwm));
  // =====
  // clock and helpers
  always #5 clk = ~clk;
  // every period match is counted, with the spacing of the last two
  always @(posedge clk)
  begin
    if (pm === 1'b1)
    begin
      n_match <= n_match + 1;
      pm_gap <= int'(($time - pm_t) / 10);
      pm_t <= $time;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // a wait that ran out counts as a mismatch
  task automatic tmo;
    n_fail++;
    $display("wait ran out at %0t", $time);
    conclude();
  endtask : tmo
  // write: address and data together, bready held until bvalid
  task automatic wr32(input logic [4:0] ad, input logic [31:0] dt, input logic [1:0] e);
    int n;
    awv <= 1; awa <= ad; wv <= 1; wd <= dt; br <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
      if (bv) break;
    end
    r = bre;
    br <= 0;
    if (n == 50) tmo();
    @(posedge clk);
    chk(r, e);
  endtask : wr32
  // read: data and response taken at the rvalid edge
  task automatic rd32(input logic [4:0] ad);
    int n;
    arv <= 1; ara <= ad; rr <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv) break;
    end
    d = rdat; r = rre;
    rr <= 0;
    if (n == 50) tmo();
    @(posedge clk);
  endtask : rd32
  task automatic wpm;
    int n;
    for (n = 0; n < 3000 && pm !== 1'b1; n++) @(posedge clk);
    if (n == 3000) tmo();
  endtask : wpm
  task automatic wirq;
    int n;
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
    if (n == 3000) tmo();
  endtask : wirq
  // =====
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    foreach (ra[i])
    begin
      rd32(ra[i]);
      chk(d, rv0[i]);
      chk(r, RESP_OKAY);
    end
    // unmapped place refused
    rd32(5'h14);
    chk(r, RESP_SLVERR);
    wr32(5'h14, 32'h1, RESP_SLVERR);
    $display("test registers done");
    wr32(ADDR_PERIOD, 32'h3, RESP_OKAY);
    foreach (rows[i])
    begin
      wr32(ADDR_TIMER_CONTROL, {25'h0, rows[i].pre, rows[i].post}, RESP_OKAY);
      wr32(ADDR_IRQ, 32'h3, RESP_OKAY);
      wr32(ADDR_TIMER_CONTROL, {25'h1, rows[i].pre, rows[i].post}, RESP_OKAY);
      // leftover postscaler state is unknown, so count between two flag sets
      wirq();
      p0 = n_match;
      wr32(ADDR_IRQ, 32'h3, RESP_OKAY);
      @(posedge clk);
      wirq();
      chk(pm_gap, rows[i].gap);
      chk(n_match - p0, rows[i].hits);
      $display("test row %0d done", i);
    end
    // mask hides the line, flag stays latched
    wr32(ADDR_IRQ, 32'h0, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    rd32(ADDR_IRQ);
    chk(d, 32'h1);
    // free run wraps to zero
    wr32(ADDR_PERIOD, 32'h5, RESP_OKAY);
    wr32(ADDR_TIMER_CONTROL, 32'h0000_0080, RESP_OKAY);
    wpm();
    chk(cnt, 8'h05);
    @(posedge clk);
    chk(cnt, 8'h00);
    wr32(ADDR_TIMER_CONTROL, 32'h0, RESP_OKAY);
    a = cnt;
    repeat (10) @(posedge clk);
    chk(cnt, a);
    $display("test free run done");
    // early reset on rising edge
    wr32(ADDR_PERIOD, 32'hFF, RESP_OKAY);
    wr32(ADDR_LIMIT_CONTROL, {27'h0, M_EDGE_RISE_RST}, RESP_OKAY);
    wr32(ADDR_TIMER_CONTROL, 32'h0000_0080, RESP_OKAY);
    repeat (40) @(posedge clk);
    lvl <= 1;
    repeat (9) @(posedge clk);
    chk(cnt < 8'h08, 1'b1);
    chk(pwm, 1'b1);
    // high level halts in the gate mode
    wr32(ADDR_LIMIT_CONTROL, {27'h0, M_GATE_HIGH_STOP}, RESP_OKAY);
    repeat (6) @(posedge clk);
    a = cnt;
    repeat (6) @(posedge clk);
    chk(cnt, a);
    lvl <= 0;
    repeat (8) @(posedge clk);
    chk(cnt > a, 1'b1);
    // high level holds the count reset
    wr32(ADDR_LIMIT_CONTROL, {27'h0, M_LEVEL_HIGH_RST}, RESP_OKAY);
    lvl <= 1;
    repeat (10) @(posedge clk);
    chk(cnt, 8'h00);
    lvl <= 0;
    $display("test external signal done");
    // one-shot stops and drops the enable
    wr32(ADDR_TIMER_CONTROL, 32'h0, RESP_OKAY);
    wr32(ADDR_PERIOD, 32'h4, RESP_OKAY);
    wr32(ADDR_LIMIT_CONTROL, {27'h0, M_OS_SOFT}, RESP_OKAY);
    wr32(ADDR_TIMER_CONTROL, 32'h0000_0080, RESP_OKAY);
    wpm();
    repeat (4) @(posedge clk);
    chk(cnt, 8'h00);
    rd32(ADDR_TIMER_CONTROL);
    chk(d, 32'h0);
    $display("test one-shot done");
    conclude();
  end
endmodule : tb
`default_nettype wire
